// file: adccmd_pkg.sv
// constants, opcodes and layouts of the serial command decoder
// assumes a single core clock; the serial link has its own clock pin
//
// Summary of operation
// R1: register checksum sums all control bytes, carries dropped, id/ready/io bits masked
// R2: bank checksum sums every byte of the bank in opcode bits 2:0
// R3: all-bank checksum sums every byte of every RAM bank, no masking
// R4: flash checksum sums every byte of every flash page, no masking
// R5: combined self calibration loads both offset and full-scale registers
// R6: offset self calibration loads only the offset correction register
// R7: gain self calibration loads only the full-scale register
// R8: system offset calibration loads offset register from present input
// R9: system gain calibration loads full-scale register from present input
// R10: synchronise opcode restarts conversion timing and data-ready
// R11: sleep opcode enters low-power sleep, suspending operation
// R12: host pulses serial clock to wake; device leaves sleep on it
// R13: soft reset restores registers, ends continuous read, keeps RAM
// R14: device is slave only and never drives the serial clock
// R15: transfers are full duplex, both lines timed by serial clock
// R16: chip select high keeps data output off and input ignored
// R17: polarity pin picks serial clock idle level, format unchanged
// R18: continuous read outputs each new result on every data-ready; the code only sets the cont_read_o flag
// R19: incoming bytes are msb first; a config bit sets output order
// R20: host holds chip select low for the whole transaction
// R21: control register set holds sixteen registers
// R22: reserved opcodes change nothing
package adccmd_pkg;

   // memory sizes
   localparam int unsigned CFG_REGS    = 16;
   localparam int unsigned RAM_BANKS   = 8;
   localparam int unsigned BANK_BYTES  = 16;
   localparam int unsigned RAM_BYTES   = 128;
   localparam int unsigned FLASH_BYTES = 4096;

   // opcodes
   localparam logic [7:0] OP_RDATAC_START = 8'h03;
   localparam logic [7:0] OP_STOP_CONT    = 8'h0f;
   localparam logic [7:0] OP_REG_SUM      = 8'hdf;
   localparam logic [4:0] OP_BANK_SUM_HI  = 5'h1c;
   localparam logic [7:0] OP_ALL_BANK_SUM = 8'he8;
   localparam logic [7:0] OP_FLASH_SUM    = 8'hec;
   localparam logic [7:0] OP_SELF_CAL     = 8'hf0;
   localparam logic [7:0] OP_SELF_OCAL    = 8'hf1;
   localparam logic [7:0] OP_SELF_GCAL    = 8'hf2;
   localparam logic [7:0] OP_SYS_OCAL     = 8'hf3;
   localparam logic [7:0] OP_SYS_GCAL     = 8'hf4;
   localparam logic [7:0] OP_SYNC         = 8'hfc;
   localparam logic [7:0] OP_SLEEP        = 8'hfd;
   localparam logic [7:0] OP_SOFT_RESET   = 8'hfe;

   // register layout
   localparam logic [3:0] IDX_STATUS   = 4'h0;
   localparam logic [7:0] MASK_STATUS  = 8'h0f;
   localparam logic [3:0] IDX_ACR      = 4'h2;
   localparam int unsigned ACR_BIT_ORDER = 3;
   localparam logic [3:0] IDX_DIO      = 4'h6;
   localparam logic [7:0] MASK_DIO     = 8'h00;
   localparam logic [3:0] IDX_MDEC1    = 4'h7;
   localparam logic [7:0] MASK_MDEC1   = 8'h7f;
   localparam logic [7:0] MASK_NONE    = 8'hff;

   // power-up values, one byte per control register, 24 bits per calibration register
   localparam logic [8*16-1:0] CFG_RESET =
      128'h00_00_00_00_00_00_00_00_00_00_00_00_00_40_00_00;
   localparam logic [23:0] OCR_RESET = 24'h000000;
   localparam logic [23:0] FSR_RESET = 24'h595555;

   // calibration kinds
   typedef enum logic [2:0] {
      ADCCMD_CAL_SELF  = 3'h0,
      ADCCMD_CAL_SOFF  = 3'h1,
      ADCCMD_CAL_SGAIN = 3'h2,
      ADCCMD_CAL_YOFF  = 3'h3,
      ADCCMD_CAL_YGAIN = 3'h4
   } adccmd_cal_t;

   // checksum sources
   typedef enum logic [1:0] {
      ADCCMD_SRC_REG   = 2'h0,
      ADCCMD_SRC_RAM   = 2'h1,
      ADCCMD_SRC_FLASH = 2'h2
   } adccmd_src_t;

   // engine states, gray along idle -> sum / idle -> cal
   typedef enum logic [1:0] {
      ADCCMD_IDLE = 2'b00,
      ADCCMD_SUM  = 2'b01,
      ADCCMD_CAL  = 2'b10
   } adccmd_state_t;

endpackage : adccmd_pkg

// file: adccmd_decoder.sv
// serial slave port and single-byte command decoder with checksum,
// calibration, sync, sleep and soft reset handling
// assumes sclk, cs_n and din come from an outside master; calibration
// results come from core-clocked analog control logic
`timescale 1ns/1ps

module adccmd_decoder
   import adccmd_pkg::*;
(
   // core clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   // serial pins
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   input  wire logic        clock_polarity_pin_i,
   output logic             dout_o,
   output logic             dout_oe_o,
   // control register loading
   input  wire logic        cfg_wr_en_i,
   input  wire logic [3:0]  cfg_wr_addr_i,
   input  wire logic [7:0]  cfg_wr_data_i,
   // memory loading
   input  wire logic        ram_wr_en_i,
   input  wire logic [6:0]  ram_wr_addr_i,
   input  wire logic [7:0]  ram_wr_data_i,
   input  wire logic        flash_wr_en_i,
   input  wire logic [11:0] flash_wr_addr_i,
   input  wire logic [7:0]  flash_wr_data_i,
   // calibration handshake
   input  wire logic        cal_done_i,
   input  wire logic [23:0] cal_offset_i,
   input  wire logic [23:0] cal_gain_i,
   output logic             cal_start_o,
   output adccmd_cal_t      cal_kind_o,
   output logic [23:0]      offset_correction_reg_o,
   output logic [23:0]      full_scale_reg_o,
   // status and control
   output logic [7:0]       checksum_o,
   output logic             sum_done_o,
   output logic             busy_o,
   output logic             sleep_o,
   output logic             cont_read_o,
   output logic             sync_pulse_o
);

   // core-side answer and order flops, read across by the link side
   logic [7:0] tx_data_reg;
   logic       tx_tgl_reg;
   logic       lsb_first_reg;

   // ---------------- link domain ----------------
   // polarity strap folds into the clock so the format is unchanged
   logic       link_clk;
   logic [2:0] bit_cnt_reg;
   logic [6:0] rx_shift_reg;
   logic [7:0] rx_byte_reg  = 8'h00;
   logic       rx_tgl_reg   = 1'b0;
   logic       wake_tgl_reg = 1'b0;
   logic [7:0] tx_stage_reg = 8'h00;
   logic [7:0] tx_next_reg  = 8'h00;
   logic [1:0] tx_tgl_sync  = 2'b00;
   logic       tx_seen_reg  = 1'b0;
   logic [1:0] order_sync   = 2'b00;
   logic [2:0] tx_idx;

   assign link_clk = sclk_i ^ clock_polarity_pin_i; // R17 R14

   // bit counter cleared while deselected
   always_ff @(posedge link_clk or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt_reg <= 3'h0; // R16
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // receive shift, msb first
   always_ff @(posedge link_clk) begin
      if (!cs_n_i) begin // R16
         rx_shift_reg <= {rx_shift_reg[5:0], din_i}; // R19 R15
         if (bit_cnt_reg == 3'h7) begin
            rx_byte_reg <= {rx_shift_reg, din_i};
            rx_tgl_reg  <= ~rx_tgl_reg;
         end
      end
   end

   // every rising link clock edge is a wake strobe, selected or not
   always_ff @(posedge link_clk) begin
      wake_tgl_reg <= ~wake_tgl_reg; // R12
   end

   // answer byte handed over by toggle, staged at byte boundaries
   always_ff @(posedge link_clk) begin
      tx_tgl_sync <= {tx_tgl_sync[0], tx_tgl_reg};
      order_sync  <= {order_sync[0], lsb_first_reg};
      if (tx_tgl_sync[1] != tx_seen_reg) begin
         tx_seen_reg <= tx_tgl_sync[1];
         tx_next_reg <= tx_data_reg;
      end
      if (bit_cnt_reg == 3'h7) begin
         tx_stage_reg <= tx_next_reg;
      end
   end

   // output order chosen by the configuration bit
   assign tx_idx = order_sync[1] ? bit_cnt_reg : 3'h7 - bit_cnt_reg; // R19

   // data driven on the falling edge, released while deselected
   always_ff @(negedge link_clk or posedge cs_n_i) begin
      if (cs_n_i) begin
         dout_o    <= 1'b0; // R16
         dout_oe_o <= 1'b0;
      end else begin
         dout_o    <= tx_stage_reg[tx_idx]; // R15
         dout_oe_o <= 1'b1;
      end
   end

   // ---------------- core domain ----------------
   logic [2:0]  rx_sync;
   logic [2:0]  wake_sync;
   logic        rx_evt;
   logic        wake_evt;
   logic [7:0]  op;

   logic [7:0]  cfg_mem [CFG_REGS];   // R21
   logic [7:0]  ram_mem [RAM_BYTES];
   logic [7:0]  flash_mem [FLASH_BYTES];

   adccmd_state_t state_reg;
   adccmd_src_t   src_reg;
   logic [11:0]   idx_reg;
   logic [11:0]   last_reg;
   logic [7:0]    acc_reg;
   logic [7:0]    fetch;
   logic          soft_rst;

   // toggles cross by two flops, the third only feeds the edge test
   always_ff @(posedge core_clk_i) begin
      rx_sync   <= {rx_sync[1:0], rx_tgl_reg};
      wake_sync <= {wake_sync[1:0], wake_tgl_reg};
   end

   assign rx_evt   = rx_sync[2] ^ rx_sync[1];
   assign wake_evt = wake_sync[2] ^ wake_sync[1];
   assign op       = rx_byte_reg;
   assign soft_rst = rx_evt && (op == OP_SOFT_RESET); // R13

   // byte fetched for the running sum, masked per register
   always_comb begin
      fetch = 8'h00;
      case (src_reg)
         ADCCMD_SRC_REG: begin
            fetch = cfg_mem[idx_reg[3:0]];
            case (idx_reg[3:0])
               IDX_STATUS: fetch = fetch & MASK_STATUS; // R1
               IDX_DIO:    fetch = fetch & MASK_DIO;    // R1
               IDX_MDEC1:  fetch = fetch & MASK_MDEC1;  // R1
               default:    fetch = fetch & MASK_NONE;
            endcase
         end
         ADCCMD_SRC_RAM:   fetch = ram_mem[idx_reg[6:0]];   // R2 R3
         ADCCMD_SRC_FLASH: fetch = flash_mem[idx_reg];      // R4
         default:          fetch = 8'h00;
      endcase
   end

   // control registers; soft reset restores power-up values
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || soft_rst) begin
         for (int i = 0; i < CFG_REGS; i++) begin
            cfg_mem[i] <= CFG_RESET[8*i +: 8]; // R13
         end
      end else if (cfg_wr_en_i) begin
         cfg_mem[cfg_wr_addr_i] <= cfg_wr_data_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      lsb_first_reg <= cfg_mem[IDX_ACR][ACR_BIT_ORDER]; // R19
   end

   // RAM survives soft reset, so it has no reset at all
   always_ff @(posedge core_clk_i) begin
      if (ram_wr_en_i) begin
         ram_mem[ram_wr_addr_i] <= ram_wr_data_i; // R13
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (flash_wr_en_i) begin
         flash_mem[flash_wr_addr_i] <= flash_wr_data_i;
      end
   end

   // command engine; commands arriving while busy are dropped, except soft reset, which restarts it, and the sync and continuous read bytes, decoded below
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || soft_rst) begin
         state_reg   <= ADCCMD_IDLE;
         src_reg     <= ADCCMD_SRC_REG;
         idx_reg     <= 12'h000;
         last_reg    <= 12'h000;
         acc_reg     <= 8'h00;
         cal_start_o <= 1'b0;
         cal_kind_o  <= ADCCMD_CAL_SELF;
         sum_done_o  <= 1'b0;
         busy_o      <= 1'b0;
      end else begin
         cal_start_o <= 1'b0;
         sum_done_o  <= 1'b0;
         case (state_reg)
            ADCCMD_IDLE: begin
               acc_reg <= 8'h00;
               if (rx_evt && !sleep_o) begin
                  if (op == OP_REG_SUM) begin
                     src_reg   <= ADCCMD_SRC_REG; // R1
                     idx_reg   <= 12'h000;
                     last_reg  <= 12'(CFG_REGS - 1);
                     state_reg <= ADCCMD_SUM;
                     busy_o    <= 1'b1;
                  end else if (op[7:3] == OP_BANK_SUM_HI) begin
                     src_reg   <= ADCCMD_SRC_RAM; // R2
                     idx_reg   <= {5'h00, op[2:0], 4'h0};
                     last_reg  <= {5'h00, op[2:0], 4'hf};
                     state_reg <= ADCCMD_SUM;
                     busy_o    <= 1'b1;
                  end else if (op == OP_ALL_BANK_SUM) begin
                     src_reg   <= ADCCMD_SRC_RAM; // R3
                     idx_reg   <= 12'h000;
                     last_reg  <= 12'(RAM_BYTES - 1);
                     state_reg <= ADCCMD_SUM;
                     busy_o    <= 1'b1;
                  end else if (op == OP_FLASH_SUM) begin
                     src_reg   <= ADCCMD_SRC_FLASH; // R4
                     idx_reg   <= 12'h000;
                     last_reg  <= 12'(FLASH_BYTES - 1);
                     state_reg <= ADCCMD_SUM;
                     busy_o    <= 1'b1;
                  end else if (op >= OP_SELF_CAL && op <= OP_SYS_GCAL) begin
                     cal_kind_o  <= adccmd_cal_t'(op[2:0]); // R5 R6 R7
                     cal_start_o <= 1'b1;                   // R8 R9
                     state_reg   <= ADCCMD_CAL;
                     busy_o      <= 1'b1;
                  end
               end
            end
            ADCCMD_SUM: begin
               acc_reg <= acc_reg + fetch; // R1 R2 R3 R4
               idx_reg <= idx_reg + 12'h001;
               if (idx_reg == last_reg) begin
                  state_reg  <= ADCCMD_IDLE;
                  sum_done_o <= 1'b1;
                  busy_o     <= 1'b0;
               end
            end
            ADCCMD_CAL: begin
               if (cal_done_i) begin
                  state_reg <= ADCCMD_IDLE;
                  busy_o    <= 1'b0;
               end
            end
            default: begin
               state_reg <= ADCCMD_IDLE; // R22
               busy_o    <= 1'b0;
            end
         endcase
      end
   end

   // checksum result, also queued as the next answer byte
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         checksum_o  <= 8'h00;
         tx_data_reg <= 8'h00;
         tx_tgl_reg  <= 1'b0;
      end else if (state_reg == ADCCMD_SUM && idx_reg == last_reg) begin
         checksum_o  <= acc_reg + fetch;
         tx_data_reg <= acc_reg + fetch;
         tx_tgl_reg  <= ~tx_tgl_reg;
      end
   end

   // calibration results land only in the registers the kind names
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || soft_rst) begin
         offset_correction_reg_o <= OCR_RESET; // R13
         full_scale_reg_o        <= FSR_RESET;
      end else if (state_reg == ADCCMD_CAL && cal_done_i) begin
         if (cal_kind_o == ADCCMD_CAL_SELF ||
             cal_kind_o == ADCCMD_CAL_SOFF ||
             cal_kind_o == ADCCMD_CAL_YOFF) begin
            offset_correction_reg_o <= cal_offset_i; // R5 R6 R8
         end
         if (cal_kind_o == ADCCMD_CAL_SELF ||
             cal_kind_o == ADCCMD_CAL_SGAIN ||
             cal_kind_o == ADCCMD_CAL_YGAIN) begin
            full_scale_reg_o <= cal_gain_i; // R5 R7 R9
         end
      end
   end

   // sleep: the entering byte beats a wake strobe seen the same cycle
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sleep_o <= 1'b0;
      end else if (rx_evt && op == OP_SLEEP && state_reg == ADCCMD_IDLE) begin
         sleep_o <= 1'b1; // R11
      end else if (wake_evt) begin
         sleep_o <= 1'b0; // R12
      end
   end

   // continuous read flag and conversion resync strobe
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || soft_rst) begin
         cont_read_o  <= 1'b0; // R13
         sync_pulse_o <= 1'b0;
      end else begin
         sync_pulse_o <= rx_evt && !sleep_o && op == OP_SYNC; // R10
         if (rx_evt && !sleep_o && op == OP_RDATAC_START) begin
            cont_read_o <= 1'b1; // R18
         end else if (rx_evt && op == OP_STOP_CONT) begin
            cont_read_o <= 1'b0;
         end
      end
   end

endmodule : adccmd_decoder

// file: adccmd_properties.sv
// port checks for the serial command decoder
// assumes binding to adccmd_decoder; core clock domain only
`timescale 1ns/1ps

module adccmd_properties
   import adccmd_pkg::*;
(
   // clock, reset and link
   input logic        core_clk_i,
   input logic        sys_rst_i,
   input logic        sclk_i,
   input logic        cs_n_i,
   input logic        dout_o,
   input logic        dout_oe_o,
   // engine
   input logic        cal_done_i,
   input logic [23:0] cal_offset_i,
   input logic [23:0] cal_gain_i,
   input logic        cal_start_o,
   input adccmd_cal_t cal_kind_o,
   input logic [23:0] offset_correction_reg_o,
   input logic [23:0] full_scale_reg_o,
   input logic        sum_done_o,
   input logic        busy_o,
   input logic        sleep_o,
   input logic        sync_pulse_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   logic cal_end;
   logic off_kind;
   logic gain_kind;
   assign cal_end   = cal_done_i && busy_o;
   assign off_kind  = cal_kind_o inside
      {ADCCMD_CAL_SELF, ADCCMD_CAL_SOFF, ADCCMD_CAL_YOFF};
   assign gain_kind = cal_kind_o inside
      {ADCCMD_CAL_SELF, ADCCMD_CAL_SGAIN, ADCCMD_CAL_YGAIN};

   AST_CS_IDLE: assert property (cs_n_i |-> !dout_oe_o && !dout_o)
      else $error("data out active while deselected");
   AST_SUM_END: assert property
      (sum_done_o |-> $past(busy_o) && !busy_o ##1 !sum_done_o)
      else $error("checksum done pulse out of place");
   AST_CAL_START: assert property
      (cal_start_o |-> busy_o ##1 busy_o && !cal_start_o)
      else $error("calibration start pulse out of place");
   AST_OFF_LOAD: assert property (cal_end && off_kind |=>
      offset_correction_reg_o == $past(cal_offset_i) && !busy_o)
      else $error("offset register not loaded");
   AST_OFF_KEEP: assert property
      (cal_end && !off_kind |=> $stable(offset_correction_reg_o))
      else $error("offset register changed by gain calibration");
   AST_GAIN_LOAD: assert property (cal_end && gain_kind |=>
      full_scale_reg_o == $past(cal_gain_i))
      else $error("full-scale register not loaded");
   AST_GAIN_KEEP: assert property
      (cal_end && !gain_kind |=> $stable(full_scale_reg_o))
      else $error("full-scale register changed by offset calibration");
   AST_SYNC: assert property (sync_pulse_o |=> !sync_pulse_o)
      else $error("sync pulse longer than one cycle");
   AST_WAKE: assert property
      (sleep_o && $changed(sclk_i) |-> ##[1:8] !sleep_o)
      else $error("no wake after serial clock edge");

   cover property (sum_done_o);
   cover property (cal_start_o);
   cover property ($fell(sleep_o));
endmodule : adccmd_properties

// file: adccmd_host.sv
// serial host model: master of the link pins
// assumes the bench calls one task at a time
`timescale 1ns/1ps

module adccmd_host (
   // polarity strap shared with the device
   input  logic pol_i,
   // link pins
   output wire  sclk_o,
   output logic cs_n_o,
   output logic din_o
);
   localparam int HALF = 80;
   logic act = 1'b0;

   // a clean rising edge clears the device's bit counter and data-out flops at start
   initial begin
      cs_n_o = 1'b0;
      #1 cs_n_o = 1'b1;
   end
   initial din_o = 1'b1;
   // only the host makes the clock; between frames it moves only for the wake pulse or a change of the polarity strap
   assign sclk_o = act ^ pol_i;

   task automatic xfer(input logic [7:0] b, input logic sel);
      #37;
      cs_n_o = !sel;
      for (int i = 7; i >= 0; i--) begin
         din_o = b[i];
         #HALF act = 1'b1;
         #HALF act = 1'b0;
      end
      #HALF cs_n_o = 1'b1;
      // released line, no pull: show the inverse, not a held value
      din_o = !din_o;
   endtask : xfer

   task automatic wake;
      #37 act = 1'b1;
      #HALF act = 1'b0;
   endtask : wake
endmodule : adccmd_host

// file: testbench.sv
// self-checking bench for the serial command decoder
// link driven by the host model, loading and calibration directly
`timescale 1ns/1ps

module testbench;
   import adccmd_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, clock_polarity_pin = 1'b0, cal_done = 1'b0;
   logic [2:0]  we = 3'h0;
   logic [11:0] wa = 12'h000;
   logic [7:0]  wd = 8'h00, csum, e, tot, fs = 8'h00;
   logic [23:0] cal_off = 24'h0, cal_gain = 24'h0, offset_correction_reg, full_scale_reg, e_ocr, e_fsr;
   logic        sclk, cs_n, din, dout, dout_oe, cal_start, sum_done;
   logic        busy, sleep, cont_rd, sync_p;
   adccmd_cal_t kind;
   logic [127:0] cv;
   logic [7:0]  mem [128];
   logic [7:0]  rsv [4] = '{8'hf5, 8'hff, 8'he9, 8'h30};
   int          error_cnt = 0, checks = 0, cyc = 0, syncs = 0, n;

   always #25 clk = ~clk;
   always @(posedge clk) if (sync_p === 1'b1) syncs++;

   adccmd_host adccmd_host_inst (.pol_i(clock_polarity_pin), .sclk_o(sclk),
      .cs_n_o(cs_n), .din_o(din));
   adccmd_decoder adccmd_decoder_inst (.core_clk_i(clk), .sys_rst_i(rst),
      .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
      .clock_polarity_pin_i(clock_polarity_pin), .dout_o(dout), .dout_oe_o(dout_oe),
      .cfg_wr_en_i(we[0]), .cfg_wr_addr_i(wa[3:0]), .cfg_wr_data_i(wd),
      .ram_wr_en_i(we[1]), .ram_wr_addr_i(wa[6:0]), .ram_wr_data_i(wd),
      .flash_wr_en_i(we[2]), .flash_wr_addr_i(wa), .flash_wr_data_i(wd),
      .cal_done_i(cal_done), .cal_offset_i(cal_off), .cal_gain_i(cal_gain),
      .cal_start_o(cal_start), .cal_kind_o(kind),
      .offset_correction_reg_o(offset_correction_reg), .full_scale_reg_o(full_scale_reg),
      .checksum_o(csum), .sum_done_o(sum_done), .busy_o(busy),
      .sleep_o(sleep), .cont_read_o(cont_rd), .sync_pulse_o(sync_p));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask : tick

   // strobe stays up between writes; caller lowers it
   task automatic wr(input int s, input logic [11:0] a, input logic [7:0] d);
      wa = a;
      wd = d;
      we = 3'(1 << s);
      tick(1);
   endtask : wr

   task automatic cmd(input logic [7:0] op, input logic sel = 1'b1);
      tick(1);
      adccmd_host_inst.xfer(op, sel);
      tick(6);
   endtask : cmd

   task automatic wsum(input logic [7:0] exp);
      n = 0;
      while (busy !== 1'b0 && n < 5000) begin
         tick(1);
         n++;
      end
      chk(24'(busy), 24'h0);
      chk(24'(csum), 24'(exp));
   endtask : wsum

   function automatic logic [7:0] rsum(input logic [127:0] v);
      logic [7:0] m;
      rsum = 8'h00;
      for (int i = 0; i < 16; i++) begin
         m = (i == IDX_STATUS) ? MASK_STATUS : (i == IDX_DIO) ? MASK_DIO :
             (i == IDX_MDEC1) ? MASK_MDEC1 : MASK_NONE;
         rsum += v[8*i +: 8] & m;
      end
   endfunction : rsum

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end

   initial begin
      tick(5);
      rst = 1'b0;
      tick(4);
      for (int i = 0; i < 16; i++) begin
         cv[8*i +: 8] = 8'(i * 37 + 5);
         wr(0, 12'(i), cv[8*i +: 8]);
      end
      for (int a = 0; a < 128; a++) begin
         mem[a] = 8'(a * 7 + 3);
         wr(1, 12'(a), mem[a]);
      end
      for (int a = 0; a < 4096; a++) begin
         wr(2, 12'(a), 8'(a ^ (a >> 5)));
         fs += 8'(a ^ (a >> 5));
      end
      we = 3'h0;
      cmd(OP_REG_SUM);
      wsum(rsum(cv));
      tot = 8'h00;
      for (int b = 0; b < 8; b++) begin
         e = 8'h00;
         for (int k = 0; k < 16; k++) e += mem[b*16 + k];
         tot += e;
         cmd({OP_BANK_SUM_HI, 3'(b)});
         wsum(e);
      end
      cmd(OP_ALL_BANK_SUM);
      wsum(tot);
      cmd(OP_FLASH_SUM);
      wsum(fs);
      $display("checksum test done");
      e_ocr = OCR_RESET;
      e_fsr = FSR_RESET;
      for (int k = 0; k < 5; k++) begin
         cmd(OP_SELF_CAL + 8'(k));
         chk(24'(kind), 24'(k));
         chk(24'(busy), 24'h1);
         cal_off = 24'h100000 + 24'(k);
         cal_gain = 24'h200000 + 24'(k);
         cal_done = 1'b1;
         tick(1);
         cal_done = 1'b0;
         if (k != 2 && k != 4) e_ocr = cal_off;
         if (k != 1 && k != 3) e_fsr = cal_gain;
         tick(1);
         chk(offset_correction_reg, e_ocr);
         chk(full_scale_reg, e_fsr);
      end
      $display("calibration test done");
      foreach (rsv[i]) begin
         cmd(rsv[i]);
         chk(24'({busy, sleep, cont_rd}), 24'h0);
         chk(24'(kind), 24'h4);
         chk(offset_correction_reg, e_ocr);
      end
      cmd(OP_SYNC);
      chk(24'(syncs), 24'h1);
      cmd(OP_SYNC, 1'b0);
      chk(24'(syncs), 24'h1);
      $display("reserved and sync test done");
      cmd(OP_SLEEP);
      chk(24'(sleep), 24'h1);
      tick(1);
      adccmd_host_inst.wake();
      tick(8);
      chk(24'(sleep), 24'h0);
      $display("sleep test done");
      cmd(OP_RDATAC_START);
      chk(24'(cont_rd), 24'h1);
      cmd(OP_SOFT_RESET);
      chk(24'({offset_correction_reg, cont_rd}), 24'({OCR_RESET, 1'b0}));
      chk(full_scale_reg, FSR_RESET);
      cmd(OP_ALL_BANK_SUM);
      wsum(tot);
      cmd(OP_REG_SUM);
      wsum(rsum(CFG_RESET));
      $display("soft reset test done");
      rst = 1'b1;
      clock_polarity_pin = 1'b1;
      tick(5);
      rst = 1'b0;
      tick(4);
      cmd(OP_REG_SUM);
      wsum(rsum(CFG_RESET));
      cmd(OP_SYNC);
      chk(24'(syncs), 24'h2);
      $display("polarity test done");
      stop_test();
   end
endmodule : testbench

bind adccmd_decoder adccmd_properties adccmd_properties_inst (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i),
   .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
   .cal_done_i(cal_done_i), .cal_offset_i(cal_offset_i),
   .cal_gain_i(cal_gain_i), .cal_start_o(cal_start_o),
   .cal_kind_o(cal_kind_o), .offset_correction_reg_o(offset_correction_reg_o),
   .full_scale_reg_o(full_scale_reg_o), .sum_done_o(sum_done_o),
   .busy_o(busy_o), .sleep_o(sleep_o), .sync_pulse_o(sync_pulse_o));
